// ---- testbench/pmc_ext_device.sv ----
module pmc_ext_device (
  input  wire logic       pclk,
  input  wire logic       sel_n,
  input  wire logic       ack_pol,
  input  wire logic [31:0] ack_dly,
  input  wire logic [7:0] rd_val,
  output logic      [7:0] data_pins_i = 8'h00,
  output logic            ack = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  always @(posedge pclk) begin
    n <= (sel_n !== 1'b0) ? 0 : n + 1;
    ack <= (sel_n === 1'b0 && n >= ack_dly) ? ack_pol : !ack_pol;
    // released bus toggles
    data_pins_i <= (sel_n !== 1'b0) ? ~data_pins_i : rd_val;
  end
endmodule // pmc_ext_device

// ---- testbench/pmc_port_config_bench.sv ----
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, x); end end
module pmc_port_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, d_o, d_oe, d_i, wdat, rd_val = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, wr_o, wr_oe, rd_o, rd_oe, lo_o, lo_oe, hi_o, hi_oe;
  logic [14:0] a_o, a_oe;
  logic [1:0]  s_o, s_oe;
  logic        ack, e, bsy, ack_pol = 0;
  int          ack_dly = 0, num_errors = 0, num_checks = 0, cnt[4] = '{0, 0, 0, 0}, b[4];
  always #25 pclk = ~pclk;
  pmc_port_config pmc_port_config_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .write_strobe_pin_o(wr_o), .write_strobe_pin_oe(wr_oe),
    .read_strobe_pin_o(rd_o), .read_strobe_pin_oe(rd_oe), .low_lane_enable_out_o(lo_o),
    .low_lane_enable_out_oe(lo_oe), .high_lane_enable_out_o(hi_o),
    .high_lane_enable_out_oe(hi_oe), .address_pins_o(a_o), .address_pins_oe(a_oe),
    .select_pin_o(s_o), .select_pin_oe(s_oe), .data_pins_o(d_o), .data_pins_oe(d_oe),
    .data_pins_i(d_i), .ack_input({ack, ack}));
  pmc_ext_device pmc_ext_device_i (.pclk(pclk), .sel_n(s_o[0]), .ack_pol(ack_pol),
    .ack_dly(ack_dly), .rd_val(rd_val), .data_pins_i(d_i), .ack(ack));
  // ==========
  // pin activity counters
  always @(posedge pclk) begin
    cnt[0] <= cnt[0] + int'(s_o[0] === 1'b0);
    cnt[1] <= cnt[1] + int'(a_o[0] === 1'b1);
    cnt[2] <= cnt[2] + int'(wr_o === 1'b0);
    cnt[3] <= cnt[3] + int'(rd_o === 1'b0);
    if (wr_o === 1'b0) wdat <= d_o;
  end
  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task lim(input int i, input int n);
    if (i >= n) begin
      num_errors++;
      test_done();
    end
  endtask
  task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    lim(i, 9);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] x);
    ap(0, a, 0);
    `CHK(r, x)
  endtask
  task go(input logic [31:0] cmd);
    int i;
    b = cnt;
    ap(1, 8'h18, cmd);
    for (i = 0; i < 200; i++) begin
      ap(0, 8'h00, 0);
      if (i == 0) bsy = r[15];
      if (r[15] === 1'b0) break;
    end
    lim(i, 200);
    foreach (b[k]) b[k] = cnt[k] - b[k];
  endtask
  logic [7:0]  ma[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] mx[6] = '{32'hFF, 32'hF700, 32'h7FFF, 32'hF7E0, 32'hF7E0, 32'hFF0F};
  logic [31:0] em[3] = '{32'h0, 32'h3, 32'h3};
  logic [31:0] ec[3] = '{32'h2000, 32'h2040, 32'hA000};
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 0; a <= 32; a += 4) rc(8'(a), 0);
    ap(1, 8'h24, 32'hFFFFFFFF);
    `CHK({e, r}, {1'b1, 32'h0})
    foreach (ma[k]) begin
      ap(1, ma[k], 32'hFFFFFFFF);
      rc(ma[k], mx[k]);
    end
    ap(1, 8'h00, 0);
    ap(1, 8'h0C, 32'h7600);
    @(posedge pclk);
    `CHK({s_o[0], wr_o, rd_o, lo_o, hi_o}, 5'h00)
    ap(1, 8'h0C, 32'h2000);
    @(posedge pclk);
    `CHK({s_o[0], wr_o, rd_o, lo_o, hi_o}, 5'h1F)
    ap(1, 8'h14, 32'h3);
    for (int c = 0; c < 8; c++) begin
      ap(1, 8'h04, 32'hF000 | (c << 8));
      go(32'h100 | c * 17);
      `CHK(b[0], 4 + 4 * (c >> 1) + ((c & 1) ? 5 : 1))
      `CHK(b[1], 2 + 4 * (c >> 1))
      `CHK({b[2], wdat, bsy}, {32'd2, 8'(c * 17), 1'b1})
    end
    ap(1, 8'h14, 32'hB);
    ap(1, 8'h0C, 32'h2080);
    ack_pol <= 1;
    ack_dly <= 3;
    rd_val <= 8'hA5;
    go(0);
    rc(8'h20, 32'hA5);
    `CHK(b[3] >= 3, 1'b1)
    ap(1, 8'h0C, 32'h20A0);
    rd_val <= 8'h3C;
    go(0);
    rc(8'h20, 32'h0C);
    ap(1, 8'h14, 32'h3);
    ap(1, 8'h0C, 32'h2100);
    go(0);
    `CHK({b[2], b[3] != 0}, {32'd3, 1'b1})
    ap(1, 8'h14, 32'h207);
    ap(1, 8'h0C, 32'h2080);
    ack_dly <= 1000;
    go(32'h100);
    rc(8'h00, 32'h1000);
    ap(1, 8'h00, 32'h1000);
    rc(8'h00, 32'h0);
    foreach (em[k]) begin
      ap(1, 8'h14, em[k]);
      ap(1, 8'h0C, ec[k]);
      go(32'h100);
      rc(8'h00, 32'h2000);
      ap(1, 8'h00, 32'h2000);
    end
    ap(1, 8'h10, 32'h2000);
    ap(1, 8'h00, 32'h10);
    ap(1, 8'h1C, 32'h100000);
    go(32'h300);
    rc(8'h00, 32'h2010);
    ap(1, 8'h00, 32'h2000);
    ap(1, 8'h1C, 32'hFF0000);
    go(32'h300);
    rc(8'h00, 32'h0);
    ap(1, 8'h1C, 32'h7FF8);
    @(posedge pclk);
    `CHK(a_o, 15'h7FF8)
    test_done();
  end
endmodule // pmc_port_config_bench

// ---- testbench/pmc_port_config_properties.sv ----
module pmc_port_config_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        write_strobe_pin_oe,
  input wire logic        read_strobe_pin_oe,
  input wire logic        low_lane_enable_out_oe,
  input wire logic        high_lane_enable_out_oe,
  input wire logic [14:0] address_pins_o,
  input wire logic [14:0] address_pins_oe,
  input wire logic [1:0]  select_pin_oe,
  input wire logic [7:0]  data_pins_oe
);
  // ==========
  // write data two edges back
  logic [31:0] wd1;
  logic [31:0] wd2;
  always_ff @(posedge pclk) begin
    wd1 <= pwdata;
    wd2 <= wd1;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  property p_strobe_oe;
    s_wr(8'h04) |=> ##1 {write_strobe_pin_oe, read_strobe_pin_oe} == wd2[15:14];
  endproperty
  property p_lane_oe;
    s_wr(8'h04) |=> ##1 {high_lane_enable_out_oe, low_lane_enable_out_oe} == wd2[13:12];
  endproperty
  property p_addr_oe;
    s_wr(8'h08) |=> ##1 address_pins_oe == wd2[14:0];
  endproperty
  property p_sel1_oe;
    s_wr(8'h0C) |=> ##1 select_pin_oe[0] == (wd2[13] && !wd2[15]);
  endproperty
  property p_sel2_oe;
    s_wr(8'h10) |=> ##1 select_pin_oe[1] == (wd2[13] && !wd2[15]);
  endproperty
  property p_oe_hold;
    !(psel && penable && pwrite) |=> ##1 $stable(address_pins_oe) && $stable(select_pin_oe);
  endproperty
  property p_latch_pins;
    address_pins_o[2:1] == 2'b00;
  endproperty
  property p_width_oe;
    data_pins_oe inside {8'h00, 8'h0F, 8'hFF};
  endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("strobe pin enable wrong");
  a_lane_oe: assert property (p_lane_oe) else $error("lane pin enable wrong");
  a_addr_oe: assert property (p_addr_oe) else $error("address pin enable wrong");
  a_sel1_oe: assert property (p_sel1_oe) else $error("select one enable wrong");
  a_sel2_oe: assert property (p_sel2_oe) else $error("select two enable wrong");
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved");
  a_latch_pins: assert property (p_latch_pins) else $error("latch pins driven");
  a_width_oe: assert property (p_width_oe) else $error("bad data enable");
endmodule // pmc_port_config_properties

bind pmc_port_config pmc_port_config_properties pmc_port_config_properties_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .write_strobe_pin_oe,
  .read_strobe_pin_oe, .low_lane_enable_out_oe, .high_lane_enable_out_oe,
  .address_pins_o, .address_pins_oe, .select_pin_oe, .data_pins_oe
);

// ---- verilog/pmc_params.svh ----
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// =====================================================================
// register byte offsets
`define PMC_OFF_CTRL_STAT   8'h00
`define PMC_OFF_STROBE_WAIT 8'h04
`define PMC_OFF_ADDR_EN     8'h08
`define PMC_OFF_CS1_CFG     8'h0C
`define PMC_OFF_CS2_CFG     8'h10
`define PMC_OFF_MODE        8'h14
`define PMC_OFF_CMD         8'h18
`define PMC_OFF_ADDR        8'h1C
`define PMC_OFF_RDATA       8'h20

// =====================================================================
// parallel_control_status fields
`define PMC_CS_BUSY         15
`define PMC_CS_ERROR        13
`define PMC_CS_TIMEOUT      12
`define PMC_CS_RESERVED_UPPER_ADDRESS_LSB    0
`define PMC_CS_RESET        16'h0000

// parallel_strobe_wait_config fields
`define PMC_SW_WREN         15
`define PMC_SW_RDEN         14
`define PMC_SW_BE1EN        13
`define PMC_SW_BE0EN        12
`define PMC_SW_AWAIT_LSB    9
`define PMC_SW_AHOLD        8
`define PMC_SW_MASK         16'hF700
`define PMC_SW_RESET        16'h0000

// parallel_address_pin_enable
`define PMC_AE_MASK         16'h7FFF
`define PMC_AE_RESET        16'h0000

// chip_select_config fields
`define PMC_CF_DIS          15
`define PMC_CF_POL          14
`define PMC_CF_PEN          13
`define PMC_CF_BEP          12
`define PMC_CF_WRITE_STROBE_POLARITY         10
`define PMC_CF_READ_STROBE_POLARITY         9
`define PMC_CF_SM           8
`define PMC_CF_ACK_POLARITY         7
`define PMC_CF_SZ_LSB       5
`define PMC_CF_MASK         16'hF7E0
`define PMC_CF_RESET        16'h0000

// port mode register fields
`define PMC_MD_MODE_LSB     0
`define PMC_MD_ACKM_LSB     2
`define PMC_MD_TLIM_LSB     8
`define PMC_MD_MASK         16'hFF0F
`define PMC_MD_RESET        16'h0000

// command register fields
`define PMC_CMD_WRITE       8
`define PMC_CMD_CS2         9

// =====================================================================
// encodings
`define PMC_MODE_MASTER     2'h3
`define PMC_SZ_8BIT         2'h0
`define PMC_SZ_4BIT         2'h1
`define PMC_ACKM_NONE       2'h0
`define PMC_ACKM_TMO        2'h1
`define PMC_ACKM_ACK        2'h2
`define PMC_TLIM_MAX        8'hFF

// =====================================================================
// timing
`define PMC_CLK_NS          50
`define PMC_TCY_NS          200
`define PMC_QTR_CYCLES      ((`PMC_TCY_NS / 4) / `PMC_CLK_NS)
`define PMC_AHOLD_SHORT_Q   1
`define PMC_AHOLD_LONG_Q    5
`define PMC_DATA_WR_Q       2
`define PMC_DATA_RD_Q       3

`endif

// ---- verilog/pmc_pkg.sv ----
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_IDLE,
    PMC_ADDR,
    PMC_AHOLD,
    PMC_DATA,
    PMC_ACK
  } pmc_state_e;

endpackage

// ---- verilog/pmc_port_config.sv ----
`include "pmc_params.svh"

// How it works
// R1 - busy flag bit 15 is high while a transaction runs
// R2 - error flag bit 13 sets when an illegal transaction is requested
// R3 - time-out flag bit 12 sets when acknowledge never arrives in time
// R4 - busy is hardware only; error and time-out clear by software write
// R5 - zero reserved upper address lets chip select 2 reach the top address
// R6 - write/enable strobe pin belongs to the port when its enable is set
// R7 - read or read/write strobe pin belongs to the port when enabled
// R8 - high and low lane enable pins each have their own pin enable
// R9 - latch strobe width is one half plus whole cycles per code
// R10 - address hold after latch is one quarter or five quarters
// R11 - address pin fourteen joins the port when its enable is set
// R12 - address pins thirteen to three each join the port when enabled
// R13 - address pins two to zero carry address or latch strobes when enabled; here pin 0 carries the latch strobe and pins 2 and 1 drive low
// R14 - a set disable bit turns its chip select off
// R15 - chip select polarity bit chooses active high or active low
// R16 - chip select pin enable hands that pin to the port
// R17 - lane enable polarity per chip select applies to both lane pins
// R18 - strobe style picks read/write strobes or direction plus enable
// R19 - write polarity bit sets write strobe or enable strobe polarity
// R20 - read polarity bit sets read strobe or direction polarity
// R21 - acknowledge input polarity per chip select; far end drives that level
// R22 - bus width code 00 is eight bits, 01 four bits, others reserved
// R23 - mode code 11 is master; transactions run only in master mode
// R24 - with time-out mode, missing acknowledge ends transfer within limit
// R25 - phases are timed on a quarter instruction cycle grid
module pmc_port_config (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              write_strobe_pin_o,
  output logic              write_strobe_pin_oe,
  output logic              read_strobe_pin_o,
  output logic              read_strobe_pin_oe,
  output logic              low_lane_enable_out_o,
  output logic              low_lane_enable_out_oe,
  output logic              high_lane_enable_out_o,
  output logic              high_lane_enable_out_oe,
  output logic       [14:0] address_pins_o,
  output logic       [14:0] address_pins_oe,
  output logic       [1:0]  select_pin_o,
  output logic       [1:0]  select_pin_oe,
  output logic       [7:0]  data_pins_o,
  output logic       [7:0]  data_pins_oe,
  input  wire  logic [7:0]  data_pins_i,
  input  wire  logic [1:0]  ack_input
);

  // ===================================================================
  // registers
  logic [15:0]          ctrl_stat;
  logic [15:0]          strobe_cfg;
  logic [15:0]          addr_en;
  logic [15:0]          cs_cfg [2];
  logic [15:0]          mode_reg;
  logic [23:0]          xfer_addr;
  logic [7:0]           xfer_wdata;
  logic                 xfer_write;
  logic                 xfer_cs2;
  logic [7:0]           rdata;
  pmc_pkg::pmc_state_e  state;
  pmc_pkg::pmc_state_e  next_state;
  logic [9:0]           qcnt;
  logic [9:0]           next_qcnt;

  // ===================================================================
  // apb decode
  wire        setup_rd   = psel & ~penable & ~pwrite;
  wire        acc_wr     = psel & penable & pwrite;
  wire        hit_stat   = (paddr == `PMC_OFF_CTRL_STAT);
  wire        hit_strobe = (paddr == `PMC_OFF_STROBE_WAIT);
  wire        hit_addren = (paddr == `PMC_OFF_ADDR_EN);
  wire        hit_cs1    = (paddr == `PMC_OFF_CS1_CFG);
  wire        hit_cs2    = (paddr == `PMC_OFF_CS2_CFG);
  wire        hit_mode   = (paddr == `PMC_OFF_MODE);
  wire        hit_cmd    = (paddr == `PMC_OFF_CMD);
  wire        hit_addr   = (paddr == `PMC_OFF_ADDR);
  wire        hit_rdata  = (paddr == `PMC_OFF_RDATA);
  wire        mapped     = hit_stat | hit_strobe | hit_addren | hit_cs1 | hit_cs2 |
                           hit_mode | hit_cmd | hit_addr | hit_rdata;
  wire [15:0] wr16       = pwdata[15:0];

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ===================================================================
  // configuration fields
  wire        busy       = (state != pmc_pkg::PMC_IDLE);
  wire [1:0]  port_mode  = mode_reg[`PMC_MD_MODE_LSB +: 2];
  wire [1:0]  ack_mode   = mode_reg[`PMC_MD_ACKM_LSB +: 2];
  wire [7:0]  tlim_raw   = mode_reg[`PMC_MD_TLIM_LSB +: 8];
  wire [7:0]  tlim       = (tlim_raw == 8'h00) ? `PMC_TLIM_MAX : tlim_raw;
  wire [7:0]  reserved_upper_address      = ctrl_stat[`PMC_CS_RESERVED_UPPER_ADDRESS_LSB +: 8];
  wire        master     = (port_mode == `PMC_MODE_MASTER);

  // selected chip select for a new command (from write data) and current one
  wire        req_cs2    = wr16[`PMC_CMD_CS2];
  wire [15:0] req_cfg    = req_cs2 ? cs_cfg[1] : cs_cfg[0];
  wire [15:0] cur_cfg    = xfer_cs2 ? cs_cfg[1] : cs_cfg[0];
  wire [1:0]  req_sz     = req_cfg[`PMC_CF_SZ_LSB +: 2];
  wire [1:0]  cur_sz     = cur_cfg[`PMC_CF_SZ_LSB +: 2];
  wire        cur_sm     = cur_cfg[`PMC_CF_SM];

  // ===================================================================
  // command check
  wire        cmd_wr     = acc_wr & hit_cmd;
  // R5 - reserved space check
  wire        in_rsvd    = req_cs2 & (reserved_upper_address != 8'h00) & (xfer_addr[23:16] >= reserved_upper_address);
  // R22 - reserved widths
  wire        bad_size   = (req_sz != `PMC_SZ_8BIT) & (req_sz != `PMC_SZ_4BIT);
  // R14 - disabled select
  wire        cs_off     = req_cfg[`PMC_CF_DIS];
  // R23 - master only
  wire        illegal    = ~master | busy | cs_off | bad_size | in_rsvd |
                           (ack_mode == 2'h3);
  wire        start      = cmd_wr & ~illegal;

  // ===================================================================
  // input synchronisers: ack and data pins
  wire  [9:0] syf;
  wire  [9:0] raw_in = {ack_input, data_pins_i};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
      logic sy1;
      logic sy2;
      logic sy3;
      logic syk;
      assign syf[gi] = syk;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sy1 <= 1'b0;
          sy2 <= 1'b0;
          sy3 <= 1'b0;
          syk <= 1'b0;
        end else begin
          sy1 <= raw_in[gi];
          sy2 <= sy1;
          sy3 <= sy2;
          if (sy2 == sy3) begin
            syk <= sy3;
          end
        end
      end
    end
  endgenerate

  wire [7:0] data_sync = syf[7:0];
  wire       ack_raw   = xfer_cs2 ? syf[9] : syf[8];
  // R21 - ack polarity
  wire       ack_seen  = (ack_raw == cur_cfg[`PMC_CF_ACK_POLARITY]);

  // ===================================================================
  // phase lengths in pclk cycles
  // R25 - quarter grid
  // R9 - latch strobe width
  wire [9:0] aw_q     = 10'(2 + 4 * strobe_cfg[`PMC_SW_AWAIT_LSB +: 2]);
  // R10 - address hold
  wire [9:0] ah_q     = strobe_cfg[`PMC_SW_AHOLD] ? 10'(`PMC_AHOLD_LONG_Q)
                                                  : 10'(`PMC_AHOLD_SHORT_Q);
  wire [9:0] dt_q     = xfer_write ? 10'(`PMC_DATA_WR_Q) : 10'(`PMC_DATA_RD_Q);
  wire [9:0] aw_len   = 10'(aw_q * `PMC_QTR_CYCLES);
  wire [9:0] ah_len   = 10'(ah_q * `PMC_QTR_CYCLES);
  wire [9:0] dt_len   = 10'(dt_q * `PMC_QTR_CYCLES);
  wire [9:0] tmo_len  = 10'(tlim * 4 * `PMC_QTR_CYCLES);
  wire       last_q   = (next_qcnt == 10'h000);
  wire       use_ack  = (ack_mode != `PMC_ACKM_NONE);
  wire       timed    = (ack_mode == `PMC_ACKM_TMO);
  wire       tmo_hit  = (state == pmc_pkg::PMC_ACK) & ~ack_seen & timed &
                        (qcnt == tmo_len - 10'h001);
  wire       finish   = ((state == pmc_pkg::PMC_DATA) & (qcnt == dt_len - 10'h001) &
                         ~use_ack) |
                        ((state == pmc_pkg::PMC_ACK) & ack_seen) | tmo_hit;

  // ===================================================================
  // sequencer
  always_comb begin
    next_state = state;
    next_qcnt  = qcnt + 10'h001;
    case (state)
      pmc_pkg::PMC_IDLE: begin
        next_qcnt = 10'h000;
        if (start) begin
          next_state = pmc_pkg::PMC_ADDR;
        end
      end
      pmc_pkg::PMC_ADDR: begin
        if (qcnt == aw_len - 10'h001) begin
          next_state = pmc_pkg::PMC_AHOLD;
          next_qcnt  = 10'h000;
        end
      end
      pmc_pkg::PMC_AHOLD: begin
        if (qcnt == ah_len - 10'h001) begin
          next_state = pmc_pkg::PMC_DATA;
          next_qcnt  = 10'h000;
        end
      end
      pmc_pkg::PMC_DATA: begin
        if (qcnt == dt_len - 10'h001) begin
          next_state = use_ack ? pmc_pkg::PMC_ACK : pmc_pkg::PMC_IDLE;
          next_qcnt  = 10'h000;
        end
      end
      pmc_pkg::PMC_ACK: begin
        // R24 - ack or time-out
        if (ack_seen || tmo_hit) begin
          next_state = pmc_pkg::PMC_IDLE;
          next_qcnt  = 10'h000;
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_IDLE;
        next_qcnt  = 10'h000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pmc_pkg::PMC_IDLE;
      qcnt  <= 10'h000;
    end else begin
      state <= next_state;
      qcnt  <= next_qcnt;
    end
  end

  // ===================================================================
  // status register
  // R2 - error set
  wire set_err  = cmd_wr & illegal;
  // R3 - time-out set
  wire set_tmo  = tmo_hit;
  wire wr_stat  = acc_wr & hit_stat;
  // R4 - software clears by writing one, a same-cycle set wins
  wire next_err = set_err | (ctrl_stat[`PMC_CS_ERROR] & ~(wr_stat & wr16[`PMC_CS_ERROR]));
  wire next_tmo = set_tmo |
                  (ctrl_stat[`PMC_CS_TIMEOUT] & ~(wr_stat & wr16[`PMC_CS_TIMEOUT]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_stat <= `PMC_CS_RESET;
    end else begin
      ctrl_stat[`PMC_CS_ERROR]   <= next_err;
      ctrl_stat[`PMC_CS_TIMEOUT] <= next_tmo;
      if (wr_stat) begin
        ctrl_stat[`PMC_CS_RESERVED_UPPER_ADDRESS_LSB +: 8] <= wr16[7:0];
      end
    end
  end

  // ===================================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_cfg <= `PMC_SW_RESET;
      addr_en    <= `PMC_AE_RESET;
      cs_cfg[0]  <= `PMC_CF_RESET;
      cs_cfg[1]  <= `PMC_CF_RESET;
      mode_reg   <= `PMC_MD_RESET;
      xfer_addr  <= 24'h000000;
    end else if (acc_wr) begin
      if (hit_strobe) strobe_cfg <= wr16 & `PMC_SW_MASK;
      if (hit_addren) addr_en    <= wr16 & `PMC_AE_MASK;
      if (hit_cs1)    cs_cfg[0]  <= wr16 & `PMC_CF_MASK;
      if (hit_cs2)    cs_cfg[1]  <= wr16 & `PMC_CF_MASK;
      if (hit_mode)   mode_reg   <= wr16 & `PMC_MD_MASK;
      if (hit_addr && !busy) xfer_addr <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_wdata <= 8'h00;
      xfer_write <= 1'b0;
      xfer_cs2   <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      if (start) begin
        xfer_wdata <= wr16[7:0];
        xfer_write <= wr16[`PMC_CMD_WRITE];
        xfer_cs2   <= req_cs2;
      end
      if (finish && !xfer_write) begin
        rdata <= (cur_sz == `PMC_SZ_4BIT) ? {4'h0, data_sync[3:0]} : data_sync;
      end
    end
  end

  // ===================================================================
  // read data
  // R1 - busy in status
  wire [15:0] stat_rd = {busy, 1'b0, ctrl_stat[`PMC_CS_ERROR], ctrl_stat[`PMC_CS_TIMEOUT],
                         4'h0, reserved_upper_address};
  wire [15:0] rd_mux  = hit_stat   ? stat_rd    :
                        hit_strobe ? strobe_cfg :
                        hit_addren ? addr_en    :
                        hit_cs1    ? cs_cfg[0]  :
                        hit_cs2    ? cs_cfg[1]  :
                        hit_mode   ? mode_reg   :
                        hit_rdata  ? {8'h00, rdata} : 16'h0000;
  wire [31:0] rd_word = hit_addr ? {8'h00, xfer_addr} : {16'h0000, rd_mux};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_word;
    end
  end

  // ===================================================================
  // pin levels
  wire in_addr  = (state == pmc_pkg::PMC_ADDR);
  wire in_data  = (state == pmc_pkg::PMC_DATA) | (state == pmc_pkg::PMC_ACK);
  wire wr_act   = in_data & xfer_write;
  wire rd_act   = in_data & ~xfer_write;
  // R18 - strobe style
  // R19 - write or enable polarity
  wire nx_wr    = (master & cur_sm) ? ~(in_data ^ cur_cfg[`PMC_CF_WRITE_STROBE_POLARITY])
                                    : ~(wr_act ^ cur_cfg[`PMC_CF_WRITE_STROBE_POLARITY]);
  // R20 - read or direction polarity
  wire nx_rd    = (master & cur_sm) ? ~(~xfer_write ^ cur_cfg[`PMC_CF_READ_STROBE_POLARITY])
                                    : ~(rd_act ^ cur_cfg[`PMC_CF_READ_STROBE_POLARITY]);
  // R17 - lane polarity
  wire lane_enable_polarity      = cur_cfg[`PMC_CF_BEP];
  wire nx_be0   = ~(in_data ^ lane_enable_polarity);
  wire nx_be1   = ~((in_data & (cur_sz == `PMC_SZ_8BIT)) ^ lane_enable_polarity);
  // R15 - select polarity
  wire [1:0] sel_act = {busy & xfer_cs2, busy & ~xfer_cs2};
  wire [1:0] nx_sel  = {~(sel_act[1] ^ cs_cfg[1][`PMC_CF_POL]),
                        ~(sel_act[0] ^ cs_cfg[0][`PMC_CF_POL])};
  // R16 - select pin ownership; R14 - disabled select releases it
  wire [1:0] nx_sel_oe = {cs_cfg[1][`PMC_CF_PEN] & ~cs_cfg[1][`PMC_CF_DIS],
                          cs_cfg[0][`PMC_CF_PEN] & ~cs_cfg[0][`PMC_CF_DIS]};
  // R13 - pin 0 carries the address latch strobe during the address phase, pins 2 and 1 drive low
  wire [14:0] nx_addr = {xfer_addr[14:3], 2'b00, in_addr};
  // data pins: low address byte in address phase, write data in data phase
  wire [7:0] nx_dat   = in_addr ? xfer_addr[7:0] : xfer_wdata;
  wire [7:0] sz_mask  = (cur_sz == `PMC_SZ_4BIT) ? 8'h0F : 8'hFF;
  wire [7:0] nx_dat_oe = ((in_addr | wr_act) & master) ? sz_mask : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_strobe_pin_o      <= 1'b0;
      write_strobe_pin_oe     <= 1'b0;
      read_strobe_pin_o       <= 1'b0;
      read_strobe_pin_oe      <= 1'b0;
      low_lane_enable_out_o   <= 1'b0;
      low_lane_enable_out_oe  <= 1'b0;
      high_lane_enable_out_o  <= 1'b0;
      high_lane_enable_out_oe <= 1'b0;
      address_pins_o          <= 15'h0000;
      address_pins_oe         <= 15'h0000;
      select_pin_o            <= 2'h0;
      select_pin_oe           <= 2'h0;
      data_pins_o             <= 8'h00;
      data_pins_oe            <= 8'h00;
    end else begin
      write_strobe_pin_o      <= nx_wr;
      // R6 - write pin enable
      write_strobe_pin_oe     <= strobe_cfg[`PMC_SW_WREN];
      read_strobe_pin_o       <= nx_rd;
      // R7 - read pin enable
      read_strobe_pin_oe      <= strobe_cfg[`PMC_SW_RDEN];
      low_lane_enable_out_o   <= nx_be0;
      // R8 - lane pin enables
      low_lane_enable_out_oe  <= strobe_cfg[`PMC_SW_BE0EN];
      high_lane_enable_out_o  <= nx_be1;
      high_lane_enable_out_oe <= strobe_cfg[`PMC_SW_BE1EN];
      address_pins_o          <= nx_addr;
      // R11 - pin 14 enable; R12 - pins 13..3 enable
      address_pins_oe         <= addr_en[14:0];
      select_pin_o            <= nx_sel;
      select_pin_oe           <= nx_sel_oe;
      data_pins_o             <= nx_dat;
      data_pins_oe            <= nx_dat_oe;
    end
  end

endmodule // pmc_port_config
